/* rtl/timer16_pkg.sv */
// constants for the 16-bit timer counter and input capture block
// assumes an APB slave with 8-bit address and 32-bit data, one word per register
package timer16_pkg;

    localparam int unsigned ADDR_WIDTH = 8;
    localparam int unsigned DATA_WIDTH = 32;

    // register byte addresses
    localparam logic [7:0] OFF_CTRL_A       = 8'h00;
    localparam logic [7:0] OFF_CTRL_B       = 8'h04;
    localparam logic [7:0] OFF_COUNT_LOW    = 8'h08;
    localparam logic [7:0] OFF_COUNT_HIGH   = 8'h0C;
    localparam logic [7:0] OFF_CAPTURE_LOW  = 8'h10;
    localparam logic [7:0] OFF_CAPTURE_HIGH = 8'h14;
    localparam logic [7:0] OFF_FLAGS        = 8'h18;
    localparam logic [7:0] OFF_IRQ_ENABLE   = 8'h1C;
    localparam logic [7:0] OFF_COMPARATOR   = 8'h20;
    localparam logic [7:0] OFF_PORT         = 8'h24;

    // field positions
    localparam int unsigned WGM_LOW_LSB   = 0;
    localparam int unsigned CS_LSB        = 0;
    localparam int unsigned WGM_HIGH_LSB  = 3;
    localparam int unsigned EDGE_BIT      = 6;
    localparam int unsigned NOISE_BIT     = 7;
    localparam int unsigned OVF_BIT       = 0;
    localparam int unsigned CAP_BIT       = 1;
    localparam int unsigned COMPARATOR_CAPTURE_SELECT_BIT      = 0;
    localparam int unsigned PORT_DATA_BIT = 0;
    localparam int unsigned PORT_DIR_BIT  = 1;

    // writable bits of each control register; others read as zero
    localparam logic [7:0] CTRL_A_MASK = 8'h03;
    localparam logic [7:0] CTRL_B_MASK = 8'hDF;

    // reset values
    localparam logic [7:0]  CTRL_A_RESET  = 8'h00;
    localparam logic [7:0]  CTRL_B_RESET  = 8'h00;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [15:0] CAPTURE_RESET = 16'h0000;
    localparam logic [7:0]  TEMP_RESET    = 8'h00;

    // counter limits
    localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
    localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
    localparam logic [15:0] TOP_8BIT     = 16'h00FF;
    localparam logic [15:0] TOP_9BIT     = 16'h01FF;
    localparam logic [15:0] TOP_10BIT    = 16'h03FF;

    // noise filter sample count
    localparam int unsigned FILTER_SAMPLES = 4;

    // clock select codes
    typedef enum logic [2:0] {
        CS_STOPPED  = 3'h0,
        CS_SYSTEM   = 3'h1,
        CS_PRE_0    = 3'h2,
        CS_PRE_1    = 3'h3,
        CS_PRE_2    = 3'h4,
        CS_PRE_3    = 3'h5,
        CS_EXT_FALL = 3'h6,
        CS_EXT_RISE = 3'h7
    } clock_select_type;

    // waveform mode codes this block counts in
    localparam logic [3:0] WGM_NORMAL      = 4'h0;
    localparam logic [3:0] WGM_PC_8BIT     = 4'h1;
    localparam logic [3:0] WGM_PC_9BIT     = 4'h2;
    localparam logic [3:0] WGM_PC_10BIT    = 4'h3;
    localparam logic [3:0] WGM_FAST_8BIT   = 4'h5;
    localparam logic [3:0] WGM_FAST_9BIT   = 4'h6;
    localparam logic [3:0] WGM_FAST_10BIT  = 4'h7;
    localparam logic [3:0] WGM_PFC_CAPTURE = 4'h8;
    localparam logic [3:0] WGM_PC_CAPTURE  = 4'hA;
    localparam logic [3:0] WGM_CTC_CAPTURE = 4'hC;
    localparam logic [3:0] WGM_FAST_CAPT   = 4'hE;

endpackage

/* rtl/capture_conditioner.sv */
// capture input path: synchroniser, optional four-sample filter, edge detector
// assumes raw_level is asynchronous to pclk
`timescale 1ns/1ps
module capture_conditioner
    import timer16_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic raw_level,
    input  wire logic filter_enable,
    input  wire logic rising_select,
    input  wire logic input_active,
    output logic      capture_strobe
);

    logic                      sync1_reg;
    logic                      sync2_reg;
    logic [FILTER_SAMPLES-1:0] history_reg;
    logic                      filtered_reg;
    logic                      prev_reg;
    logic                      level;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= raw_level;
            sync2_reg <= sync1_reg;
        end
    end

    // filter runs on pclk, never on the timer tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            history_reg  <= '0;
            filtered_reg <= 1'b0;
        end else begin
            history_reg <= {history_reg[FILTER_SAMPLES-2:0], sync2_reg};
            if (&history_reg) begin
                filtered_reg <= 1'b1;
            end else if (~|history_reg) begin
                filtered_reg <= 1'b0;
            end
        end
    end

    assign level = filter_enable ? filtered_reg : sync2_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg       <= 1'b0;
            capture_strobe <= 1'b0;
        end else begin
            prev_reg <= level;
            capture_strobe <= input_active && (level != prev_reg) && (level == rising_select);
        end
    end

endmodule

/* rtl/timer16_capture.sv */
// 16-bit timer counter and input capture unit with an APB register port
// assumes pclk at 20 MHz, prescaled ticks from pclk logic, async pins
//
// Functional notes
// - three-bit clock select picks tick source; zero stops the counter
// - counter readable and writable by software whether or not ticking
// - software counter write beats clear or count in same cycle
// - counter clears, increments or decrements per tick as mode selects
// - low-byte read returns low bits and loads high byte into latch
// - high-byte write only fills latch; low-byte write loads full counter
// - top indication at sequence maximum, bottom indication at zero
// - overflow flag set where mode defines; may request interrupt
// - selected edge on event input copies counter into capture value
// - capture flag sets in the same cycle as the copy
// - capture flag requests interrupt when enabled; cleared by service or one
// - capture low read loads latch; following high read returns latch
// - capture value writable only in modes using it as top
// - comparator select switches capture source; software clears false flag
// - filter output changes only after four equal consecutive samples
// - filter enable inserts filter, adds five system cycles, pclk driven
// - capture input active except in modes using capture value as top
// - every new capture overwrites capture value even if unread
// - software may trigger capture by driving the capture pin
// - one high-byte latch shared by all 16-bit registers
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module timer16_capture
    import timer16_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [3:0]  prescaled_tick,
    input  wire logic        external_count_pin,
    input  wire logic        capture_pin_in,
    output logic             capture_pin_out,
    output logic             capture_pin_oe,
    input  wire logic        comparator_output,
    input  wire logic        capture_irq_ack,
    input  wire logic        overflow_irq_ack,
    output logic             capture_irq_req,
    output logic             overflow_irq_req,
    output logic             counter_top,
    output logic             counter_bottom
);

    logic [7:0]  timer_control_a_reg;
    logic [7:0]  timer_control_b_reg;
    logic [15:0] count_value_reg;
    logic [15:0] count_value_next;
    logic        count_down_reg;
    logic        count_down_next;
    logic [15:0] capture_value_reg;
    logic [7:0]  temp_reg;
    logic [1:0]  flags_reg;
    logic [1:0]  flags_next;
    logic [1:0]  irq_enable_reg;
    logic        comparator_capture_select_reg;
    logic [1:0]  port_reg;
    logic        ext_sync1_reg;
    logic        ext_sync2_reg;
    logic        ext_prev_reg;
    logic        overflow_set;
    logic        timer_tick;
    logic        capture_event;
    logic        capture_source;
    logic [3:0]  waveform_mode_field;
    logic [2:0]  clock_source_select;
    logic [15:0] top_value;
    logic        rd_fire;
    logic        wr_fire;
    logic [31:0] rdata_next;
    logic        err_next;

    // sequence top for a mode; modes not built here count to the maximum
    function automatic logic [15:0] mode_top(input logic [3:0] mode,
                                             input logic [15:0] cap);
        case (mode)
            WGM_PC_8BIT, WGM_FAST_8BIT:   mode_top = TOP_8BIT;
            WGM_PC_9BIT, WGM_FAST_9BIT:   mode_top = TOP_9BIT;
            WGM_PC_10BIT, WGM_FAST_10BIT: mode_top = TOP_10BIT;
            WGM_PFC_CAPTURE, WGM_PC_CAPTURE,
            WGM_CTC_CAPTURE, WGM_FAST_CAPT: mode_top = cap;
            default:                      mode_top = COUNT_MAX;
        endcase
    endfunction

    function automatic logic uses_capture_top(input logic [3:0] mode);
        uses_capture_top = (mode == WGM_PFC_CAPTURE) || (mode == WGM_PC_CAPTURE) ||
                           (mode == WGM_CTC_CAPTURE) || (mode == WGM_FAST_CAPT);
    endfunction

    function automatic logic dual_slope(input logic [3:0] mode);
        dual_slope = (mode == WGM_PC_8BIT) || (mode == WGM_PC_9BIT) ||
                     (mode == WGM_PC_10BIT) || (mode == WGM_PFC_CAPTURE) ||
                     (mode == WGM_PC_CAPTURE);
    endfunction

    function automatic logic fast_pwm(input logic [3:0] mode);
        fast_pwm = (mode == WGM_FAST_8BIT) || (mode == WGM_FAST_9BIT) ||
                   (mode == WGM_FAST_10BIT) || (mode == WGM_FAST_CAPT);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        case (a)
            OFF_CTRL_A, OFF_CTRL_B, OFF_COUNT_LOW, OFF_COUNT_HIGH,
            OFF_CAPTURE_LOW, OFF_CAPTURE_HIGH, OFF_FLAGS,
            OFF_IRQ_ENABLE, OFF_COMPARATOR, OFF_PORT: mapped = 1'b1;
            default:                                  mapped = 1'b0;
        endcase
    endfunction

    assign waveform_mode_field = {timer_control_b_reg[WGM_HIGH_LSB +: 2],
                                  timer_control_a_reg[WGM_LOW_LSB +: 2]};
    assign clock_source_select = timer_control_b_reg[CS_LSB +: 3];
    assign top_value           = mode_top(waveform_mode_field, capture_value_reg);

    // one wait state: read data and read side effects at the first access
    // edge, writes at the completing edge, so each happens exactly once
    assign rd_fire = psel && penable && !pwrite && !pready;
    assign wr_fire = psel && penable && pwrite && pready;

    // external count pin: two stages, then edge detect on the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_sync1_reg <= 1'b0;
            ext_sync2_reg <= 1'b0;
            ext_prev_reg  <= 1'b0;
        end else begin
            ext_sync1_reg <= external_count_pin;
            ext_sync2_reg <= ext_sync1_reg;
            ext_prev_reg  <= ext_sync2_reg;
        end
    end

    always_comb begin
        unique case (clock_source_select)
            CS_STOPPED:  timer_tick = 1'b0;
            CS_SYSTEM:   timer_tick = 1'b1;
            CS_PRE_0:    timer_tick = prescaled_tick[0];
            CS_PRE_1:    timer_tick = prescaled_tick[1];
            CS_PRE_2:    timer_tick = prescaled_tick[2];
            CS_PRE_3:    timer_tick = prescaled_tick[3];
            CS_EXT_FALL: timer_tick = ext_prev_reg && !ext_sync2_reg;
            CS_EXT_RISE: timer_tick = !ext_prev_reg && ext_sync2_reg;
        endcase
    end

    // counting sequence
    always_comb begin
        count_value_next = count_value_reg;
        count_down_next  = count_down_reg;
        overflow_set     = 1'b0;
        if (timer_tick) begin
            if (dual_slope(waveform_mode_field)) begin
                if (!count_down_reg) begin
                    if (count_value_reg == top_value) begin
                        count_down_next  = 1'b1;
                        count_value_next = count_value_reg - 16'h0001;
                    end else begin
                        count_value_next = count_value_reg + 16'h0001;
                    end
                end else if (count_value_reg == COUNT_BOTTOM) begin
                    count_down_next  = 1'b0;
                    count_value_next = count_value_reg + 16'h0001;
                    overflow_set     = 1'b1;
                end else begin
                    count_value_next = count_value_reg - 16'h0001;
                end
            end else if ((fast_pwm(waveform_mode_field) ||
                          waveform_mode_field == WGM_CTC_CAPTURE) &&
                         count_value_reg == top_value) begin
                count_value_next = COUNT_BOTTOM;
                overflow_set     = fast_pwm(waveform_mode_field);
            end else begin
                count_value_next = count_value_reg + 16'h0001;
                overflow_set     = (count_value_reg == COUNT_MAX);
            end
        end
        if (wr_fire && paddr == OFF_COUNT_LOW) begin
            count_value_next = {temp_reg, pwdata[7:0]};
            count_down_next  = count_down_reg;
        end
        if (!dual_slope(waveform_mode_field)) begin
            count_down_next = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value_reg <= COUNT_RESET;
            count_down_reg  <= 1'b0;
        end else begin
            count_value_reg <= count_value_next;
            count_down_reg  <= count_down_next;
        end
    end

    // a late view of the indications; the counter itself uses fresh compares
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_top    <= 1'b0;
            counter_bottom <= 1'b0;
        end else begin
            counter_top    <= (count_value_reg == top_value);
            counter_bottom <= (count_value_reg == COUNT_BOTTOM);
        end
    end

    // source switch may itself make an edge; software clears the flag after
    assign capture_source = comparator_capture_select_reg ?
                            comparator_output : capture_pin_in;

    capture_conditioner u_conditioner (
        .pclk           (pclk),
        .presetn        (presetn),
        .raw_level      (capture_source),
        .filter_enable  (timer_control_b_reg[NOISE_BIT]),
        .rising_select  (timer_control_b_reg[EDGE_BIT]),
        .input_active   (!uses_capture_top(waveform_mode_field)),
        .capture_strobe (capture_event)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_value_reg <= CAPTURE_RESET;
        end else if (capture_event) begin
            capture_value_reg <= count_value_reg;
        end else if (wr_fire && paddr == OFF_CAPTURE_LOW &&
                     uses_capture_top(waveform_mode_field)) begin
            capture_value_reg <= {temp_reg, pwdata[7:0]};
        end
    end

    // shared high-byte latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_reg <= TEMP_RESET;
        end else if (wr_fire && (paddr == OFF_COUNT_HIGH || paddr == OFF_CAPTURE_HIGH)) begin
            temp_reg <= pwdata[7:0];
        end else if (rd_fire && paddr == OFF_COUNT_LOW) begin
            temp_reg <= count_value_reg[15:8];
        end else if (rd_fire && paddr == OFF_CAPTURE_LOW) begin
            temp_reg <= capture_value_reg[15:8];
        end
    end

    // flags: set wins over a write-one clear or a service acknowledge
    always_comb begin
        flags_next = flags_reg;
        if (wr_fire && paddr == OFF_FLAGS) begin
            flags_next = flags_next & ~pwdata[1:0];
        end
        if (capture_irq_ack) begin
            flags_next[CAP_BIT] = 1'b0;
        end
        if (overflow_irq_ack) begin
            flags_next[OVF_BIT] = 1'b0;
        end
        if (capture_event) begin
            flags_next[CAP_BIT] = 1'b1;
        end
        if (overflow_set) begin
            flags_next[OVF_BIT] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= 2'h0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_irq_req  <= 1'b0;
            overflow_irq_req <= 1'b0;
        end else begin
            capture_irq_req  <= flags_reg[CAP_BIT] && irq_enable_reg[CAP_BIT];
            overflow_irq_req <= flags_reg[OVF_BIT] && irq_enable_reg[OVF_BIT];
        end
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_a_reg           <= CTRL_A_RESET;
            timer_control_b_reg           <= CTRL_B_RESET;
            irq_enable_reg                <= 2'h0;
            comparator_capture_select_reg <= 1'b0;
            port_reg                      <= 2'h0;
        end else if (wr_fire) begin
            case (paddr)
                OFF_CTRL_A:     timer_control_a_reg <= pwdata[7:0] & CTRL_A_MASK;
                OFF_CTRL_B:     timer_control_b_reg <= pwdata[7:0] & CTRL_B_MASK;
                OFF_IRQ_ENABLE: irq_enable_reg <= pwdata[1:0];
                OFF_COMPARATOR: comparator_capture_select_reg <= pwdata[COMPARATOR_CAPTURE_SELECT_BIT];
                OFF_PORT:       port_reg <= pwdata[1:0];
                default:        ;
            endcase
        end
    end

    // port driver for the capture pin, lets software make its own events
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_pin_out <= 1'b0;
            capture_pin_oe  <= 1'b0;
        end else begin
            capture_pin_out <= port_reg[PORT_DATA_BIT];
            capture_pin_oe  <= port_reg[PORT_DIR_BIT];
        end
    end

    // read data
    always_comb begin
        rdata_next = 32'h0000_0000;
        err_next   = !mapped(paddr);
        case (paddr)
            OFF_CTRL_A:       rdata_next[7:0] = timer_control_a_reg;
            OFF_CTRL_B:       rdata_next[7:0] = timer_control_b_reg;
            OFF_COUNT_LOW:    rdata_next[7:0] = count_value_reg[7:0];
            OFF_COUNT_HIGH:   rdata_next[7:0] = temp_reg;
            OFF_CAPTURE_LOW:  rdata_next[7:0] = capture_value_reg[7:0];
            OFF_CAPTURE_HIGH: rdata_next[7:0] = temp_reg;
            OFF_FLAGS:        rdata_next[1:0] = flags_reg;
            OFF_IRQ_ENABLE:   rdata_next[1:0] = irq_enable_reg;
            OFF_COMPARATOR:   rdata_next[COMPARATOR_CAPTURE_SELECT_BIT] = comparator_capture_select_reg;
            OFF_PORT:         rdata_next[1:0] = port_reg;
            default:          rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready) begin
                prdata  <= pwrite ? 32'h0000_0000 : rdata_next;
                pslverr <= err_next;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

endmodule

/* verif/timer16_capture_checker.sv */
// bus and pin assertions for the timer counter and capture block
// assumes the checker is bound to the top module, one pclk domain
`timescale 1ns/1ps
module timer16_capture_checker
    import timer16_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        capture_pin_out,
    input wire logic        capture_pin_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mapped;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= OFF_PORT);
    sequence s_waiting;
        psel && penable && !pready;
    endsequence
    sequence s_done_read;
        pready && !pwrite;
    endsequence
    a_one_wait_state: assert property (s_waiting |=> pready)
        else $error("ready missing after wait state");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_needs_req: assert property (pready |-> $past(psel) && $past(penable))
        else $error("ready without request");
    a_err_unmapped: assert property (pready && !mapped |-> pslverr)
        else $error("no error on unmapped address");
    a_err_mapped: assert property (pready && mapped |-> !pslverr)
        else $error("error on mapped address");
    a_unmapped_zero: assert property (s_done_read ##0 pslverr |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_byte_wide: assert property (s_done_read |-> prdata[31:8] == 24'h0)
        else $error("read data above low byte");
    a_ctrl_b_spare: assert property (s_done_read ##0 paddr == OFF_CTRL_B |-> !prdata[5])
        else $error("spare control bit reads one");
    // register lands at the write edge, pin flop follows one edge later
    a_port_drive: assert property (pready && pwrite && paddr == OFF_PORT |-> ##2
        capture_pin_out == $past(pwdata[0], 2) && capture_pin_oe == $past(pwdata[1], 2))
        else $error("port pin not following write");
endmodule

bind timer16_capture timer16_capture_checker checker_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .capture_pin_out, .capture_pin_oe);

/* verif/event_source.sv */
// far-side model of the capture pin wire
// assumes a pull-up on the pin; bench may release its own drive
`timescale 1ns/1ps
module event_source (
    input  wire logic pin_out,
    input  wire logic pin_oe,
    input  wire logic drive_en,
    input  wire logic level,
    output logic      pin
);
    // port output wins so software can trigger a capture
    assign pin = pin_oe ? pin_out : (drive_en ? level : 1'b1);
endmodule

/* verif/test_timer16_capture.sv */
// self-checking bench: apb register tests of counter and capture
// assumes design and event_source model compiled first
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin fails++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
module test_timer16_capture
    import timer16_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, pin, pout, poe, ovf_req, cap_req, top, bot;
    logic lvl = 0, drv = 1, cmp = 0, ack = 0, st, sb;
    int fails = 0, n_checks = 0;
    always #25 pclk = ~pclk;
    event_source event_source_i (.pin_out(pout), .pin_oe(poe), .drive_en(drv), .level(lvl),
        .pin(pin));
    timer16_capture timer16_capture_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .prescaled_tick(4'h0),
        .external_count_pin(1'b0), .capture_pin_in(pin), .capture_pin_out(pout),
        .capture_pin_oe(poe), .comparator_output(cmp), .capture_irq_ack(ack),
        .overflow_irq_ack(1'b0), .capture_irq_req(cap_req), .overflow_irq_req(ovf_req),
        .counter_top(top), .counter_bottom(bot));
    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        xfer(a, 0, 8'h00);
        `CHK($sformatf("reg %h", a), e, r[7:0])
    endtask
    task automatic set16(input logic [7:0] hi, input logic [15:0] v);
        wr(hi, v[15:8]);
        wr(hi - 8'h04, v[7:0]);
    endtask
    // settle time covers synchroniser plus filter
    task automatic ev(input logic v);
        lvl <= v;
        repeat (12) @(posedge pclk);
    endtask
    task automatic results();
        if (fails == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        results();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        rd(OFF_CTRL_B, 8'h00);
        set16(OFF_COUNT_HIGH, 16'h1234);
        rd(OFF_COUNT_LOW, 8'h34);
        rd(OFF_COUNT_HIGH, 8'h12);
        wr(OFF_COUNT_HIGH, 8'h77);
        rd(OFF_CAPTURE_HIGH, 8'h77);
        repeat (20) @(posedge pclk);
        rd(OFF_COUNT_LOW, 8'h34);
        wr(OFF_IRQ_ENABLE, 8'h03);
        wr(OFF_CTRL_B, 8'h40);
        wr(OFF_FLAGS, 8'h03);
        ev(1);
        rd(OFF_CAPTURE_LOW, 8'h34);
        rd(OFF_CAPTURE_HIGH, 8'h12);
        rd(OFF_FLAGS, 8'h02);
        `CHK("cap_req", 1'b1, cap_req)
        ack <= 1;
        @(posedge pclk) ack <= 0;
        rd(OFF_FLAGS, 8'h00);
        set16(OFF_COUNT_HIGH, 16'h5678);
        ev(0);
        rd(OFF_FLAGS, 8'h00);
        wr(OFF_CTRL_B, 8'h00);
        wr(OFF_FLAGS, 8'h02);
        ev(1);
        ev(0);
        rd(OFF_CAPTURE_LOW, 8'h78);
        rd(OFF_CAPTURE_HIGH, 8'h56);
        wr(OFF_CTRL_B, 8'hC0);
        set16(OFF_COUNT_HIGH, 16'h0102);
        wr(OFF_FLAGS, 8'h02);
        lvl <= 1;
        repeat (3) @(posedge pclk);
        ev(0);
        rd(OFF_FLAGS, 8'h00);
        ev(1);
        rd(OFF_FLAGS, 8'h02);
        wr(OFF_CTRL_B, 8'h40);
        wr(OFF_COMPARATOR, 8'h01);
        wr(OFF_FLAGS, 8'h02);
        ev(0);
        ev(1);
        rd(OFF_FLAGS, 8'h00);
        cmp <= 1;
        ev(1);
        rd(OFF_FLAGS, 8'h02);
        wr(OFF_COMPARATOR, 8'h00);
        drv <= 0;
        wr(OFF_PORT, 8'h02);
        wr(OFF_FLAGS, 8'h02);
        wr(OFF_PORT, 8'h03);
        ev(1);
        rd(OFF_FLAGS, 8'h02);
        wr(OFF_PORT, 8'h00);
        drv <= 1;
        set16(OFF_CAPTURE_HIGH, 16'hABCD);
        rd(OFF_CAPTURE_LOW, 8'h02);
        wr(OFF_CTRL_B, 8'h58);
        set16(OFF_CAPTURE_HIGH, 16'h0100);
        rd(OFF_CAPTURE_LOW, 8'h00);
        rd(OFF_CAPTURE_HIGH, 8'h01);
        wr(OFF_FLAGS, 8'h02);
        ev(0);
        ev(1);
        rd(OFF_FLAGS, 8'h00);
        wr(OFF_FLAGS, 8'h03);
        wr(OFF_CTRL_B, 8'h01);
        set16(OFF_COUNT_HIGH, 16'hFFF0);
        repeat (40) @(posedge pclk);
        rd(OFF_FLAGS, 8'h01);
        `CHK("ovf_req", 1'b1, ovf_req)
        // counter ticks every pclk: a read sees the load plus edges since it
        rd(OFF_COUNT_LOW, 8'h1E);
        rd(OFF_COUNT_HIGH, 8'h00);
        set16(OFF_COUNT_HIGH, 16'h0080);
        rd(OFF_COUNT_LOW, 8'h82);
        rd(OFF_COUNT_HIGH, 8'h00);
        wr(OFF_CTRL_A, 8'h01);
        st = 0;
        sb = 0;
        repeat (600) begin
            @(posedge pclk);
            st |= top;
            sb |= bot;
        end
        `CHK("top", 1'b1, st)
        `CHK("bottom", 1'b1, sb)
        xfer(8'h40, 0, 8'h00);
        `CHK("unmapped", 32'h0, r)
        results();
    end
endmodule
